// ### logic/opc_output_powerdown_stop_control.sv
// power-down and output-halt control of an eight-pair differential clock buffer
// assumes pins are asynchronous to i_clk_sys and the reference is well below 12.5 MHz
`timescale 1ns/1ps
`default_nettype none
module opc_output_powerdown_stop_control #(
	parameter int LOCK_CYCLES = opc_pkg::LOCK_CYCLES,
	parameter int PDREL_DRIVE_CYCLES = opc_pkg::PDREL_DRIVE_CYCLES
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// device pins
	input wire logic i_input_ref_clock,
	input wire logic i_power_down_n,
	input wire logic i_output_halt_n,
	input wire logic [7:0] i_pair_enable,
	// register bus
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// output pairs
	output logic [7:0] o_diff_clock_true,
	output logic [7:0] o_true_oe,
	output logic [7:0] o_true_full_current,
	output logic [7:0] o_diff_clock_comp,
	output logic [7:0] o_comp_oe,
	// core status
	output logic o_pll_enable,
	output logic o_locked
);
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [7:0] en_s1;
	logic [7:0] en_s2;
	logic ref_q;
	logic ref_s;
	logic pd_n;
	logic halt_n;
	logic rise_comp;
	logic fall_comp;

	// pins pass two flops before use; the reference only works if it keeps running
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			pin_s1 <= opc_pkg::PIN_SYNC_RST;
			pin_s2 <= opc_pkg::PIN_SYNC_RST;
			en_s1 <= opc_pkg::OUT_EN_RST;
			en_s2 <= opc_pkg::OUT_EN_RST;
			ref_q <= 1'b0;
		end else begin
			pin_s1 <= {i_output_halt_n, i_power_down_n, i_input_ref_clock}; // RL1 RL9
			pin_s2 <= pin_s1;
			en_s1 <= i_pair_enable;
			en_s2 <= en_s1;
			ref_q <= pin_s2[0];
		end
	end

	assign ref_s = pin_s2[0];
	assign pd_n = pin_s2[1];
	assign halt_n = pin_s2[2];
	// complementary output rises when the true side falls
	assign rise_comp = ref_q & ~ref_s;
	assign fall_comp = ~ref_q & ref_s;

	// register bus
	logic [1:0] ctrl;
	logic [7:0] out_en;
	logic [7:0] stoppable;
	logic [1:0] next_ctrl;
	logic [7:0] next_out_en;
	logic [7:0] next_stoppable;
	logic next_waitrequest;
	logic [31:0] next_readdata;
	logic [7:0] halted;
	opc_pkg::opc_pd_state_t pd_state;
	opc_pkg::opc_halt_state_t h_state;
	logic halt_rec;

	function automatic logic [31:0] read_mux(input logic [3:0] addr, input logic [1:0] c,
		input logic [7:0] en, input logic [7:0] stp, input logic [31:0] stat);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (addr)
			opc_pkg::REG_CTRL: d = {30'h0000_0000, c};
			opc_pkg::REG_OUT_EN: d = {24'h00_0000, en};
			opc_pkg::REG_STOPPABLE: d = {24'h00_0000, stp};
			opc_pkg::REG_STATUS: d = stat;
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction : read_mux

	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[opc_pkg::STAT_PD_BIT] = (pd_state == opc_pkg::PD_PARKED);
		status_word[opc_pkg::STAT_LOCK_BIT] = o_locked;
		status_word[opc_pkg::STAT_HALT_BIT] = ~halt_rec;
		status_word[opc_pkg::STAT_HALTED_LSB +: 8] = halted;
	end

	// one wait cycle per access; the access completes when waitrequest is low
	always_comb begin
		next_ctrl = ctrl;
		next_out_en = out_en;
		next_stoppable = stoppable;
		next_readdata = o_avs_readdata;
		next_waitrequest = 1'b1;
		if ((i_avs_read | i_avs_write) && o_avs_waitrequest) begin
			next_waitrequest = 1'b0;
			if (i_avs_read)
				next_readdata = read_mux(i_avs_address, ctrl, out_en, stoppable, status_word);
		end
		if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]) begin
			unique case (i_avs_address)
				opc_pkg::REG_CTRL: next_ctrl = i_avs_writedata[1:0];
				opc_pkg::REG_OUT_EN: next_out_en = i_avs_writedata[7:0];
				opc_pkg::REG_STOPPABLE: next_stoppable = i_avs_writedata[7:0]; // RL17
				default: next_ctrl = ctrl;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			ctrl <= opc_pkg::CTRL_RST;
			out_en <= opc_pkg::OUT_EN_RST;
			stoppable <= opc_pkg::STOPPABLE_RST; // RL17
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			out_en <= next_out_en;
			stoppable <= next_stoppable;
			o_avs_waitrequest <= next_waitrequest;
			o_avs_readdata <= next_readdata;
		end
	end

	// power-down sequencing
	opc_pkg::opc_pd_state_t next_pd_state;
	logic [1:0] pd_cnt;
	logic [1:0] next_pd_cnt;
	logic [31:0] lock_cnt;
	logic [31:0] next_lock_cnt;

	always_comb begin
		next_pd_state = pd_state;
		next_pd_cnt = pd_cnt;
		next_lock_cnt = lock_cnt;
		if (rise_comp)
			next_pd_cnt = pd_n ? 2'h0 : ((pd_cnt == opc_pkg::QUAL_EDGES) ? pd_cnt : pd_cnt + 2'h1);
		unique case (pd_state)
			opc_pkg::PD_RUN: begin
				if (next_pd_cnt == opc_pkg::QUAL_EDGES)
					next_pd_state = opc_pkg::PD_ARM; // RL2
			end
			opc_pkg::PD_ARM: begin
				if (pd_n) begin
					next_pd_state = opc_pkg::PD_RUN;
					next_pd_cnt = 2'h0;
				end else if (fall_comp) begin
					next_pd_state = opc_pkg::PD_PARKED; // RL2
				end
			end
			opc_pkg::PD_PARKED: begin
				// release needs no clock edge of the reference
				if (pd_n) begin
					next_pd_state = opc_pkg::PD_LOCKING; // RL1
					next_lock_cnt = 32'h0000_0000;
				end
			end
			opc_pkg::PD_LOCKING: begin
				if (!pd_n) begin
					next_pd_state = opc_pkg::PD_PARKED;
				end else if (lock_cnt == 32'(LOCK_CYCLES - 1)) begin
					next_pd_state = opc_pkg::PD_RUN; // RL7
					next_pd_cnt = 2'h0;
				end else begin
					next_lock_cnt = lock_cnt + 32'h0000_0001;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			pd_state <= opc_pkg::PD_RUN;
			pd_cnt <= 2'h0;
			lock_cnt <= 32'h0000_0000;
		end else begin
			pd_state <= next_pd_state;
			pd_cnt <= next_pd_cnt;
			lock_cnt <= next_lock_cnt;
		end
	end

	// halt debounce and stop/restart sequencing
	opc_pkg::opc_halt_state_t next_h_state;
	logic halt_smp;
	logic next_halt_smp;
	logic next_halt_rec;
	logic [7:0] next_halted;
	logic [2:0] rel_cnt;
	logic [2:0] next_rel_cnt;

	always_comb begin
		next_h_state = h_state;
		next_halt_smp = halt_smp;
		next_halt_rec = halt_rec;
		next_halted = halted;
		next_rel_cnt = rel_cnt;
		if (rise_comp) begin
			next_halt_smp = halt_n;
			if (halt_smp == halt_n)
				next_halt_rec = halt_n; // RL10
		end
		unique case (h_state)
			opc_pkg::HLT_RUN: begin
				if (!halt_rec)
					next_h_state = opc_pkg::HLT_ARM;
			end
			opc_pkg::HLT_ARM: begin
				// freeze just after the true side rises, so it rests high
				if (halt_rec) begin
					next_h_state = opc_pkg::HLT_RUN;
				end else if (fall_comp) begin
					next_h_state = opc_pkg::HLT_STOPPED; // RL11
					next_halted = stoppable; // RL16
				end
			end
			opc_pkg::HLT_STOPPED: begin
				if (halt_rec) begin
					next_h_state = opc_pkg::HLT_RELEASE;
					next_rel_cnt = 3'h0;
				end
			end
			opc_pkg::HLT_RELEASE: begin
				if (!halt_rec) begin
					next_h_state = opc_pkg::HLT_STOPPED;
				end else if (fall_comp && rel_cnt >= opc_pkg::RESTART_MIN_PER) begin
					next_h_state = opc_pkg::HLT_RUN; // RL14
					next_halted = 8'h00;
				end else if (rise_comp) begin
					next_rel_cnt = rel_cnt + 3'h1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			h_state <= opc_pkg::HLT_RUN;
			halt_smp <= 1'b1;
			halt_rec <= 1'b1;
			halted <= 8'h00;
			rel_cnt <= 3'h0;
		end else begin
			h_state <= next_h_state;
			halt_smp <= next_halt_smp;
			halt_rec <= next_halt_rec;
			halted <= next_halted;
			rel_cnt <= next_rel_cnt;
		end
	end

	// pair drivers; power-down park overrides any halt park
	logic [7:0] next_true;
	logic [7:0] next_true_oe;
	logic [7:0] next_full;
	logic [7:0] next_comp;
	logic [7:0] next_comp_oe;
	logic stop_park;
	logic pd_drv;
	logic halt_drv;

	assign pd_drv = ctrl[opc_pkg::CTRL_PD_DRV_BIT];
	assign halt_drv = ctrl[opc_pkg::CTRL_HALT_DRV_BIT];

	always_comb begin
		next_true = {8{ref_s}};
		next_comp = {8{~ref_s}};
		next_true_oe = 8'hFF;
		next_comp_oe = 8'hFF;
		next_full = 8'hFF;
		stop_park = 1'b0;
		for (int i = 0; i < opc_pkg::NUM_PAIRS; i++) begin
			stop_park = (halted[i] && (h_state == opc_pkg::HLT_STOPPED ||
				h_state == opc_pkg::HLT_RELEASE)) || !out_en[i] || !en_s2[i];
			if (pd_state == opc_pkg::PD_PARKED) begin
				next_true_oe[i] = ~pd_drv; // RL3 RL4 RL5 RL18
				next_true[i] = ~pd_drv;
				next_comp[i] = 1'b0;
				next_comp_oe[i] = 1'b0;
				next_full[i] = 1'b0; // RL4
			end else if (pd_state == opc_pkg::PD_LOCKING) begin
				// driven high at once after release, well inside the allowed time
				next_true[i] = 1'b1; // RL8
				next_comp[i] = 1'b0;
				next_comp_oe[i] = 1'b0;
				next_full[i] = 1'b0;
			end else if (stop_park) begin
				next_true_oe[i] = ~halt_drv | (h_state == opc_pkg::HLT_RELEASE); // RL12 RL13 RL15
				next_true[i] = next_true_oe[i];
				next_comp[i] = 1'b0;
				next_comp_oe[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_diff_clock_true <= 8'h00;
			o_diff_clock_comp <= 8'hFF;
			o_true_oe <= 8'hFF;
			o_comp_oe <= 8'hFF;
			o_true_full_current <= 8'hFF;
			o_pll_enable <= 1'b1;
			o_locked <= 1'b0;
		end else begin
			o_diff_clock_true <= next_true;
			o_diff_clock_comp <= next_comp;
			o_true_oe <= next_true_oe;
			o_comp_oe <= next_comp_oe;
			o_true_full_current <= next_full;
			// follows the parked state, so the PLL never stops ahead of the pair park
			o_pll_enable <= (pd_state != opc_pkg::PD_PARKED); // RL3
			o_locked <= (next_pd_state == opc_pkg::PD_RUN || next_pd_state == opc_pkg::PD_ARM);
		end
	end

	// checks
	logic [31:0] undriven_wait;
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			undriven_wait <= 32'h0000_0000;
		else if (pd_state == opc_pkg::PD_LOCKING && !(&o_true_oe))
			undriven_wait <= undriven_wait + 32'h0000_0001;
		else
			undriven_wait <= 32'h0000_0000;
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	sequence s_pd_qualified;
		pd_state == opc_pkg::PD_RUN && rise_comp && !pd_n && pd_cnt == 2'h1;
	endsequence
	sequence s_park_edge;
		pd_state == opc_pkg::PD_ARM && !pd_n && fall_comp;
	endsequence

	a_pd_qualify: assert property (s_pd_qualified |=> pd_state == opc_pkg::PD_ARM) // RL2
		else $error("power-down not armed after two low samples");
	a_pd_park_edge: assert property (s_park_edge |=> pd_state == opc_pkg::PD_PARKED
		##1 (!o_pll_enable && o_comp_oe == 8'h00)) // RL2
		else $error("pairs not parked at complementary fall");
	a_powerdown_drive_select_low: assert property (pd_state == opc_pkg::PD_PARKED && !pd_drv
		|=> o_diff_clock_true == 8'hFF && o_true_oe == 8'hFF && o_true_full_current == 8'h00
		&& o_comp_oe == 8'h00) // RL4
		else $error("power-down drive mode 0 park wrong");
	a_powerdown_drive_select_hiz: assert property (pd_state == opc_pkg::PD_PARKED && pd_drv
		|=> o_true_oe == 8'h00 && o_comp_oe == 8'h00) // RL5
		else $error("power-down drive mode 1 park wrong");
	a_pll_after_park: assert property ($fell(o_pll_enable) |-> o_comp_oe == 8'h00) // RL3
		else $error("PLL stopped before outputs parked");
	a_lock_time: assert property (pd_state == opc_pkg::PD_LOCKING
		|-> lock_cnt < 32'(LOCK_CYCLES)) // RL7
		else $error("lock wait exceeded");
	a_release_drive: assert property (undriven_wait < 32'(PDREL_DRIVE_CYCLES)) // RL8
		else $error("outputs undriven too long after power-down release");
	a_halt_debounce: assert property ($changed(halt_rec)
		|-> $past(rise_comp) && $past(halt_smp) == halt_rec) // RL10
		else $error("halt change accepted without two steady samples");
	a_halt_freeze: assert property (h_state == opc_pkg::HLT_ARM && !halt_rec && fall_comp
		|=> halted == $past(stoppable)) // RL11 RL16
		else $error("stopped set differs from stoppable bits");
	a_halt_drive_low: assert property (h_state == opc_pkg::HLT_STOPPED && !halt_drv
		&& pd_state == opc_pkg::PD_RUN |=> (o_diff_clock_true & halted) == halted
		&& (o_true_oe & halted) == halted && (o_comp_oe & halted) == 8'h00) // RL12
		else $error("halt drive mode 0 park wrong");
	a_halt_hiz: assert property (h_state == opc_pkg::HLT_STOPPED && halt_drv && !halt_rec
		&& pd_state == opc_pkg::PD_RUN |=> (o_true_oe & halted) == 8'h00
		&& (o_comp_oe & halted) == 8'h00) // RL13
		else $error("halt drive mode 1 park wrong");
	a_halt_rel_drive: assert property ($rose(h_state == opc_pkg::HLT_RELEASE)
		&& pd_state == opc_pkg::PD_RUN |=> (o_true_oe & halted) == halted) // RL15
		else $error("stopped true outputs not driven after release");
	a_restart_span: assert property (h_state == opc_pkg::HLT_RELEASE
		|-> rel_cnt <= opc_pkg::RESTART_MAX_PER) // RL14
		else $error("restart later than allowed");
	a_pd_over_halt: assert property (pd_state == opc_pkg::PD_PARKED
		|=> o_true_full_current == 8'h00 && o_comp_oe == 8'h00) // RL18
		else $error("halt park overrode power-down park");
endmodule : opc_output_powerdown_stop_control
`default_nettype wire

// ### logic/opc_pkg.sv
// constants, state types and register map of the output power-down / halt control
// assumes one 25 MHz system clock and an Avalon-MM host reaching the registers
// Operation
// RL1 - power-down pin is asynchronous, active low; low powers down, high powers up
// RL2 - two consecutive complementary rises low, then park at complementary fall
// RL3 - park all pairs high or undriven before the PLL is switched off
// RL4 - drive bit 0: true driven high at low current, complement undriven
// RL5 - drive bit 1: both true and complement undriven during power-down
// RL6 - host asserts power-down before removing input clock or supply
// RL7 - locked, stable clocks less than one millisecond after power-down release
// RL8 - drive bit 1: outputs driven high within 300 us of release
// RL9 - host keeps reference clock running whenever it uses the halt pin
// RL10 - halt pin change accepted only when steady over two complementary rises
// RL11 - recognised halt stops stoppable pairs after next transition; others run
// RL12 - halt drive bit 0: stopped true driven high full current, complement undriven
// RL13 - halt drive bit 1: stopped true and complement both undriven
// RL14 - halt release restarts all stopped pairs together, glitch free, 2-6 periods
// RL15 - halt drive bit 1: stopped true driven high within 10 ns of release; here one 40 ns system clock after HLT_RELEASE is entered
// RL16 - stoppable bits select halt obedience; enable pins act independently
// RL17 - one stoppable bit per pair, 0 free-running, 1 stoppable, reset 0
// RL18 - power-down wins over halt; halted pairs take the power-down park
`default_nettype none
package opc_pkg;
	localparam int NUM_PAIRS = 8;
	localparam int CLK_PERIOD_NS = 40;
	localparam int LOCK_TIME_NS = 1000000;
	localparam int LOCK_CYCLES = LOCK_TIME_NS / CLK_PERIOD_NS;
	localparam int PDREL_DRIVE_NS = 300000;
	localparam int PDREL_DRIVE_CYCLES = PDREL_DRIVE_NS / CLK_PERIOD_NS;
	localparam int HALT_DRIVE_NS = 10;
	localparam int HALT_DRIVE_CYCLES =
		(HALT_DRIVE_NS / CLK_PERIOD_NS > 0) ? HALT_DRIVE_NS / CLK_PERIOD_NS : 1;
	localparam logic [1:0] QUAL_EDGES = 2'h2;
	localparam logic [2:0] RESTART_MIN_PER = 3'h2;
	localparam logic [2:0] RESTART_MAX_PER = 3'h6;

	// byte addresses of the register words
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_OUT_EN = 4'h4;
	localparam logic [3:0] REG_STOPPABLE = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int CTRL_PD_DRV_BIT = 0;
	localparam int CTRL_HALT_DRV_BIT = 1;
	localparam int STAT_PD_BIT = 0;
	localparam int STAT_LOCK_BIT = 1;
	localparam int STAT_HALT_BIT = 2;
	localparam int STAT_HALTED_LSB = 8;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] OUT_EN_RST = 8'hFF;
	localparam logic [7:0] STOPPABLE_RST = 8'h00;
	// sync chain reset: halt high, power-down high, reference low
	localparam logic [2:0] PIN_SYNC_RST = 3'h6;

	typedef enum logic [1:0] {
		PD_RUN,
		PD_ARM,
		PD_PARKED,
		PD_LOCKING
	} opc_pd_state_t;

	typedef enum logic [1:0] {
		HLT_RUN,
		HLT_ARM,
		HLT_STOPPED,
		HLT_RELEASE
	} opc_halt_state_t;
endpackage : opc_pkg
`default_nettype wire

// ### tb/opc_rx_model.sv
// downstream clock receivers: resolves each output wire from value and drive enable
// assumes the far end is terminated, so an undriven line rests low
`timescale 1ns/1ps
`default_nettype none
module opc_rx_model (
	// driver side
	input wire logic [7:0] i_true_val,
	input wire logic [7:0] i_true_oe,
	input wire logic [7:0] i_comp_val,
	input wire logic [7:0] i_comp_oe,
	// received levels
	output logic [7:0] o_true_level,
	output logic [7:0] o_comp_level
);
	// termination pull-down, never the last driven value
	always_comb begin
		o_true_level = i_true_val & i_true_oe;
		o_comp_level = i_comp_val & i_comp_oe;
	end
endmodule : opc_rx_model
`default_nettype wire

// ### tb/testbench.sv
// register-access and pin-sequence tests of the power-down / halt control
// assumes the downstream receiver model and a reference far below the system clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int REF_HALF = 10;
	localparam int REF_P = 20;
	localparam int LOCK = 20;
	localparam int PDREL = 4;
	localparam int TMO = 30000;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic ref_clk = 1'b0;
	logic pd_n = 1'b1;
	logic halt_n = 1'b1;
	logic [7:0] pair_en = 8'hFF;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hF;
	wire logic [31:0] rdata;
	wire logic waitreq;
	wire logic [7:0] tv, toe, full, cv, coe, tl, cl;
	wire logic pll_en;
	wire logic locked;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	int refc = 0;
	int n;
	logic [31:0] d;
	logic [7:0] m;

	opc_output_powerdown_stop_control #(.LOCK_CYCLES(LOCK), .PDREL_DRIVE_CYCLES(PDREL)) u_dut (
		.i_clk_sys(clk_sys), .i_nrst(nrst), .i_input_ref_clock(ref_clk),
		.i_power_down_n(pd_n), .i_output_halt_n(halt_n), .i_pair_enable(pair_en),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.o_diff_clock_true(tv), .o_true_oe(toe), .o_true_full_current(full),
		.o_diff_clock_comp(cv), .o_comp_oe(coe), .o_pll_enable(pll_en), .o_locked(locked));

	opc_rx_model u_rx (.i_true_val(tv), .i_true_oe(toe), .i_comp_val(cv), .i_comp_oe(coe),
		.o_true_level(tl), .o_comp_level(cl));

	always #20 clk_sys = ~clk_sys;

	// reference never stops, halt handling depends on it
	always @(posedge clk_sys) begin
		if (refc == REF_HALF - 1) begin
			refc <= 0;
			ref_clk <= ~ref_clk;
		end else begin
			refc <= refc + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic av(input logic we, input logic [3:0] a, input logic [31:0] wd,
		input logic [3:0] b, output logic [31:0] rv);
		@(posedge clk_sys);
		addr <= a;
		wdata <= wd;
		be <= b;
		wr <= we;
		rd <= ~we;
		@(posedge clk_sys);
		while (waitreq !== 1'b0) @(posedge clk_sys);
		rv = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : av

	task automatic cw(input int c);
		repeat (c) @(posedge clk_sys);
	endtask : cw

	// pairs whose received true line moved during three reference periods
	task automatic run_mask(output logic [7:0] rm);
		logic [7:0] p;
		rm = 8'h00;
		p = tl;
		repeat (3 * REF_P) begin
			@(posedge clk_sys);
			rm = rm | (tl ^ p);
			p = tl;
		end
	endtask : run_mask

	task automatic print_verdict;
		$display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == TMO) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		cw(16);
		nrst <= 1'b1;
		av(1'b0, opc_pkg::REG_CTRL, 32'h0, 4'hF, d);
		chk(d, 32'h0);
		av(1'b0, opc_pkg::REG_OUT_EN, 32'h0, 4'hF, d);
		chk(d, 32'hFF);
		av(1'b0, opc_pkg::REG_STOPPABLE, 32'h0, 4'hF, d);
		chk(d, 32'h0);
		av(1'b0, 4'h2, 32'h0, 4'hF, d);
		chk(d, 32'h0);
		av(1'b1, opc_pkg::REG_STOPPABLE, 32'h0F, 4'h0, d);
		av(1'b0, opc_pkg::REG_STOPPABLE, 32'h0, 4'hF, d);
		chk(d, 32'h0);
		av(1'b1, opc_pkg::REG_STOPPABLE, 32'hFFFFFF0F, 4'hF, d);
		av(1'b0, opc_pkg::REG_STOPPABLE, 32'h0, 4'hF, d);
		chk(d, 32'h0F);
		run_mask(m);
		chk(m, 8'hFF);
		// short pulses on both pins must be ignored
		pd_n <= 1'b0;
		halt_n <= 1'b0;
		cw(REF_HALF - 2);
		pd_n <= 1'b1;
		halt_n <= 1'b1;
		run_mask(m);
		chk(m, 8'hFF);
		chk({pll_en, locked}, 2'h3);
		// pin disable parks a free-running pair
		pair_en <= 8'hDF;
		cw(3 * REF_P);
		run_mask(m);
		chk(m, 8'hDF);
		chk({tl[5], full[5], coe[5]}, 3'h6);
		pair_en <= 8'hFF;
		// register disable parks a free-running pair the same way
		av(1'b1, opc_pkg::REG_OUT_EN, 32'hBF, 4'hF, d);
		av(1'b0, opc_pkg::REG_OUT_EN, 32'h0, 4'hF, d);
		chk(d, 32'hBF);
		cw(3 * REF_P);
		run_mask(m);
		chk(m, 8'hBF);
		av(1'b1, opc_pkg::REG_OUT_EN, 32'hFF, 4'hF, d);
		// halt, drive bit 0
		halt_n <= 1'b0;
		cw(5 * REF_P);
		run_mask(m);
		chk(m, 8'hF0);
		chk({tl[3:0], toe[3:0], full[3:0], coe[3:0]}, 16'hFFF0);
		chk(tl[7:4] ^ cl[7:4], 4'hF);
		av(1'b0, opc_pkg::REG_STATUS, 32'h0, 4'hF, d);
		chk({d[15:8], d[2]}, 9'h01F);
		halt_n <= 1'b1;
		n = 0;
		while (tl[3:0] === 4'hF && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		chk(tl[3:0], 4'h0);
		chk((n >= 2 * REF_P) && (n <= 6 * REF_P + REF_HALF), 1'b1);
		// halt, drive bit 1
		av(1'b1, opc_pkg::REG_CTRL, 32'h2, 4'hF, d);
		halt_n <= 1'b0;
		cw(5 * REF_P);
		chk({toe[3:0], coe[3:0], tl[3:0]}, 12'h000);
		halt_n <= 1'b1;
		n = 0;
		while (toe[3:0] !== 4'hF && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		chk(tl[3:0], 4'hF);
		chk(n <= 3 * REF_P, 1'b1);
		cw(8 * REF_P);
		run_mask(m);
		chk(m, 8'hFF);
		// power-down overrides a running halt, drive bit 1
		av(1'b1, opc_pkg::REG_CTRL, 32'h1, 4'hF, d);
		halt_n <= 1'b0;
		cw(5 * REF_P);
		pd_n <= 1'b0;
		cw(5 * REF_P);
		chk({toe, coe}, 16'h0);
		chk(pll_en, 1'b0);
		halt_n <= 1'b1;
		pd_n <= 1'b1;
		n = 0;
		while (toe !== 8'hFF && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		chk(tl, 8'hFF);
		chk(n <= PDREL + 8, 1'b1);
		n = 0;
		while (locked !== 1'b1 && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n <= LOCK + 10, 1'b1);
		// the halt release is still being debounced; let the stopped pairs restart
		cw(8 * REF_P);
		run_mask(m);
		chk(m, 8'hFF);
		// power-down, drive bit 0
		av(1'b1, opc_pkg::REG_CTRL, 32'h0, 4'hF, d);
		pd_n <= 1'b0;
		n = 0;
		while (pll_en !== 1'b0 && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n <= 4 * REF_P + 8, 1'b1);
		cw(4);
		chk({tl, toe, full, coe}, 32'hFFFF0000);
		av(1'b0, opc_pkg::REG_STATUS, 32'h0, 4'hF, d);
		chk(d[1:0], 2'h1);
		pd_n <= 1'b1;
		cw(LOCK + 4 * REF_P);
		chk({pll_en, locked}, 2'h3);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
